// File: bench/sspi_ctrl_sva.sv
// Checker on pin ownership, role and serial clock timing.
// Assumes binding to sspi_ctrl; sees its ports only.
`timescale 1ns/1ns
module sspi_ctrl_sva (
	input logic CLK_SYS,
	input logic RSTN,
	input logic [1:0] SERIAL_MODE_SELECT,
	input logic [3:0] PIN_FUNC_SEL,
	input logic MASTER_ROLE_BIT,
	input logic CLK_POL,
	input logic CLK_PHA,
	input logic TX_IDLE,
	input logic SPI_ACTIVE,
	input logic DMA_RX_VALID,
	input logic SCLK_OUT_FF,
	input logic SCLK_OE_N,
	input logic MOSI_OUT_FF,
	input logic MOSI_OE_N,
	input logic MISO_OE_N,
	input logic SLAVE_SELECT_IN_N
);
	default clocking @(posedge CLK_SYS); endclocking
	default disable iff (!RSTN);
	wire own = SERIAL_MODE_SELECT == 2'h2 && PIN_FUNC_SEL == 4'h1;
	wire mst = own && MASTER_ROLE_BIT;
	wire samp = !(CLK_POL ^ CLK_PHA);
	// Idle is judged over sixteen cycles so a closing half period can finish.
	sequence s_quiet;
		(mst && TX_IDLE && $stable(CLK_POL)) [*8];
	endsequence
	sequence s_sample;
		mst && $changed(SCLK_OUT_FF) && SCLK_OUT_FF == samp;
	endsequence
	AST_PINS_FREE: assert property (!own [*2] |-> SCLK_OE_N && MOSI_OE_N && MISO_OE_N)
		else $error("pins not released");
	AST_MODE_ONLY: assert property (SERIAL_MODE_SELECT != 2'h2 |-> !SPI_ACTIVE)
		else $error("active outside mode");
	AST_DMA_SPI: assert property (!SPI_ACTIVE |-> !DMA_RX_VALID)
		else $error("dma outside mode");
	AST_MST_PINS: assert property (mst [*2] |-> !SCLK_OE_N && !MOSI_OE_N && MISO_OE_N)
		else $error("master drive wrong");
	AST_SLV_PINS: assert property ((own && !MASTER_ROLE_BIT) [*2] |-> SCLK_OE_N && MOSI_OE_N)
		else $error("slave drive wrong");
	AST_IDLE_POL: assert property (s_quiet ##1 s_quiet |-> SCLK_OUT_FF == CLK_POL)
		else $error("idle level wrong");
	AST_SCLK_RATE: assert property ($changed(SCLK_OUT_FF) && !TX_IDLE |=> $stable(SCLK_OUT_FF))
		else $error("clock too fast");
	AST_MOSI_HOLD: assert property (s_sample |-> $stable(MOSI_OUT_FF))
		else $error("data moved on sample");
	AST_SLV_SEL: assert property ((own && !MASTER_ROLE_BIT && SLAVE_SELECT_IN_N) |-> MISO_OE_N)
		else $error("miso driven while deselected");
endmodule
bind sspi_ctrl sspi_ctrl_sva sspi_ctrl_sva_inst (.CLK_SYS(CLK_SYS), .RSTN(RSTN),
	.SERIAL_MODE_SELECT(SERIAL_MODE_SELECT), .PIN_FUNC_SEL(PIN_FUNC_SEL),
	.MASTER_ROLE_BIT(MASTER_ROLE_BIT), .CLK_POL(CLK_POL), .CLK_PHA(CLK_PHA),
	.TX_IDLE(TX_IDLE), .SPI_ACTIVE(SPI_ACTIVE), .DMA_RX_VALID(DMA_RX_VALID),
	.SCLK_OUT_FF(SCLK_OUT_FF), .SCLK_OE_N(SCLK_OE_N), .MOSI_OUT_FF(MOSI_OUT_FF),
	.MOSI_OE_N(MOSI_OE_N), .MISO_OE_N(MISO_OE_N), .SLAVE_SELECT_IN_N(SLAVE_SELECT_IN_N));

// File: bench/sspi_slave_model.sv
// Behavioural SPI slave answering the controller in master role.
// Assumes a load pulse between frames while the clock idles.
`timescale 1ns/1ns
module sspi_slave_model (
	input wire sclk,
	input wire mosi,
	input wire cpol,
	input wire cpha,
	input wire lsb,
	input wire load,
	input wire [7:0] load_data,
	output wire miso,
	output logic [7:0] rx_sr
);
	logic [7:0] tx_sr = 8'h00;
	logic [2:0] cnt = 3'h0;
	assign miso = lsb ? tx_sr[0] : tx_sr[7];
	// The answer rotates, so a whole frame leaves it ready for the next.
	function automatic [7:0] rot(input [7:0] v, input l);
		rot = l ? {v[0], v[7:1]} : {v[6:0], v[7]};
	endfunction
	always @(posedge load) begin
		tx_sr = load_data;
		cnt = 3'h0;
	end
	always @(sclk) begin
		if (sclk === !(cpol ^ cpha)) begin
			rx_sr = lsb ? {mosi, rx_sr[7:1]} : {rx_sr[6:0], mosi};
			if (cpha && cnt == 3'h7) tx_sr = rot(tx_sr, lsb);
			cnt = cnt + 3'h1;
		end else if (!(cpha && cnt == 3'h0)) begin
			tx_sr = rot(tx_sr, lsb);
		end
	end
endmodule

// File: bench/test_sspi_ctrl.sv
// Self-checking bench for the SPI controller in both roles.
// Assumes the slave model and the bound checker are compiled first.
`timescale 1ns/1ns
module test_sspi_ctrl;
	logic clk = 1'h0, rstn = 1'h0, tick = 1'h0, mst = 1'h1, pol = 1'h0, pha = 1'h0;
	logic lsb = 1'h0, txwr = 1'h0, rxrd = 1'h0, ssn = 1'h1, sin = 1'h0, min = 1'h0, ld = 1'h0;
	logic [1:0] mode = 2'h0;
	logic [3:0] psel = 4'h0, lin = 4'h1, ex = 4'h1;
	logic dtv = 1'h0, drr = 1'h0;
	logic [7:0] txd = 8'h00, ldd = 8'h00, dtd = 8'h00, r;
	wire [7:0] rxd, mrx;
	wire txfree, txidle, rxval, ovr, act, dmarx, sco, scoe, mo, moe, so, soe, mmiso, dtr;
	wire sclk_w = scoe ? sin : sco;
	wire mosi_w = moe ? min : mo;
	wire miso_w = soe ? mmiso : so;
	int error_cnt = 0, check_count = 0;
	time last_t = 0, half = 0;
	sspi_ctrl sspi_ctrl_inst (.CLK_SYS(clk), .RSTN(rstn), .REF_TICK(tick),
		.SERIAL_MODE_SELECT(mode), .PIN_FUNC_SEL(psel), .MASTER_ROLE_BIT(mst),
		.CLK_POL(pol), .CLK_PHA(pha), .LSB_FIRST(lsb), .CLOCK_RATE_LINEAR(lin),
		.CLOCK_RATE_EXPONENT(ex), .TX_WR(txwr), .TX_DATA(txd), .RX_RD(rxrd), .RX_DATA(rxd),
		.DMA_TX_VALID(dtv), .DMA_TX_DATA(dtd), .DMA_TX_READY(dtr), .DMA_RX_VALID(dmarx),
		.DMA_RX_READY(drr), .TX_FREE(txfree), .TX_IDLE(txidle), .RX_VALID(rxval),
		.RX_OVERRUN_FF(ovr), .SPI_ACTIVE(act), .SCLK_OUT_FF(sco), .SCLK_OE_N(scoe),
		.SCLK_IN(sclk_w), .MOSI_OUT_FF(mo), .MOSI_OE_N(moe), .MISO_IN(miso_w),
		.MISO_OUT_FF(so), .MISO_OE_N(soe), .MOSI_IN(mosi_w), .SLAVE_SELECT_IN_N(ssn));
	sspi_slave_model sspi_slave_model_inst (.sclk(sclk_w), .mosi(mosi_w), .cpol(pol),
		.cpha(pha), .lsb(lsb), .load(ld), .load_data(ldd), .miso(mmiso), .rx_sr(mrx));
	initial forever #10 clk = ~clk;
	// Reference tick every second cycle stands in for the slower reference clock.
	always @(negedge clk) tick <= ~tick;
	always @(sclk_w) begin
		half = $time - last_t;
		last_t = $time;
	end
	task chk(input logic [7:0] seen, input logic [7:0] exp);
		check_count++;
		if (seen !== exp) begin
			error_cnt++;
			$display("Error at %0t: saw %h expected %h", $time, seen, exp);
		end
	endtask
	task complete_run;
		$display("Compares %0d mismatches %0d", check_count, error_cnt);
		if (error_cnt == 0 && check_count > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	task nclk(input int n);
		repeat (n) @(negedge clk);
	endtask
	task send(input [7:0] d);
		txd = d;
		txwr = 1'h1;
		nclk(1);
		txwr = 1'h0;
		nclk(1);
	endtask
	task rd;
		rxrd = 1'h1;
		nclk(1);
		rxrd = 1'h0;
		r = rxd;
		nclk(1);
	endtask
	task ldm(input [7:0] sd);
		nclk(3);
		ldd = sd;
		ld = 1'h1;
		nclk(1);
		ld = 1'h0;
	endtask
	task xfer(input [7:0] d, input [7:0] sd);
		ldm(sd);
		send(d);
		for (int n = 0; n < 3000 && rxval !== 1'h1; n++) nclk(1);
		rd;
		chk(r, sd);
		chk(mrx, d);
	endtask
	task sbyte(input [7:0] d);
		for (int i = 7; i >= 0; i--) begin
			min = d[i];
			nclk(5);
			r = {r[6:0], miso_w};
			sin = 1'h1;
			nclk(5);
			sin = 1'h0;
		end
	endtask
	initial begin
		#1000000;
		error_cnt++;
		complete_run;
	end
	initial begin
		nclk(16);
		rstn = 1'h1;
		nclk(1);
		chk({3'h0, scoe, moe, soe, txidle, rxval}, 8'h1E);
		for (int m = 0; m < 4; m++) begin
			mode = m[1:0];
			nclk(2);
			chk({6'h0, act, dtr}, {6'h0, (m == 2), (m == 2)});
		end
		mode = 2'h2;
		nclk(2);
		chk({5'h0, scoe, moe, soe}, 8'h07);
		psel = 4'h1;
		nclk(2);
		chk({5'h0, scoe, moe, soe}, 8'h01);
		for (int i = 0; i < 8; i++) begin
			{lsb, pha, pol} = i[2:0];
			xfer(8'hA1 ^ i[7:0], 8'h5C + i[7:0]);
			chk(8'(half / 20), 8'h08);
		end
		lin = 4'h0;
		ex = 4'h0;
		{lsb, pha, pol} = 3'h0;
		ldm(8'hC3);
		for (int i = 0; i < 5; i++) send(8'h10 + i[7:0]);
		chk({7'h0, txfree}, 8'h00);
		for (int n = 0; n < 3000 && ovr !== 1'h1; n++) nclk(1);
		chk({6'h0, ovr, dmarx}, 8'h03);
		chk(mrx, 8'h14);
		chk(8'(half / 20), 8'h02);
		for (int i = 0; i < 4; i++) begin
			rd;
			chk(r, 8'hC3);
		end
		chk({7'h0, rxval}, 8'h00);
		ldm(8'hE7);
		dtd = 8'h3C;
		dtv = 1'h1;
		chk({7'h0, dtr}, 8'h01);
		nclk(1);
		dtv = 1'h0;
		for (int n = 0; n < 3000 && dmarx !== 1'h1; n++) nclk(1);
		drr = 1'h1;
		nclk(1);
		drr = 1'h0;
		chk(rxd, 8'hE7);
		chk(mrx, 8'h3C);
		mst = 1'h0;
		nclk(2);
		chk({6'h0, scoe, moe}, 8'h03);
		send(8'h69);
		sbyte(8'h96);
		nclk(20);
		chk({6'h0, rxval, txidle}, 8'h00);
		ssn = 1'h0;
		sbyte(8'h96);
		chk({7'h0, soe}, 8'h00);
		chk(r, 8'h69);
		ssn = 1'h1;
		for (int n = 0; n < 3000 && rxval !== 1'h1; n++) nclk(1);
		rd;
		chk(r, 8'h96);
		complete_run;
	end
endmodule

// File: common/sspi_defines.vh
// Constants for the synchronous serial SPI controller.
// Assumes inclusion by bare name from the design files.
`ifndef SSPI_DEFINES_VH
`define SSPI_DEFINES_VH
`define SSPI_MODE_SPI 2'h2
`define SSPI_CHAR_BITS 8
`define SSPI_FIFO_DEPTH 4
`define SSPI_FIFO_AW 2
`define SSPI_REF_MHZ 24
`define SSPI_SYS_MHZ 50
`define SSPI_SLV_MAX_MHZ 5
`define SSPI_PINSEL_SPI 4'h1
`define SSPI_RST_RATE 4'h0
`endif

// File: design/sspi_ctrl.v
// Second synchronous serial unit, SPI personality with mode select and pin ownership.
// Assumes all inputs synchronous to CLK_SYS; the reference tick stands in for 24 MHz.
`timescale 1ns/1ns
`include "sspi_defines.vh"
// Notes on behaviour
// - Only one personality runs; SPI logic idles unless SPI mode is chosen.
// - DMA path exists only in SPI mode; FIFOs are flushed and take no writes outside SPI mode.
// - Software writes transmit characters and reads received ones through a data port.
// - Every SPI character is exactly eight bits.
// - SPI is active only when mode select equals two.
// - Master and slave roles both shift in and out together.
// - Master clock is programmable, at most 12 MHz.
// - Software picks clock idle polarity and sampling phase.
// - Software picks MSB-first or LSB-first shifting.
// - Active-low slave select input is honoured only in slave role.
// - Serial signals reach shared pins only when pin select grants them.
// - Master clock is 24 MHz over 2*(linear+1)*2^exponent.
// - Separate four-character transmit and receive FIFOs.
// - Master role bit set selects master, cleared selects slave.
module sspi_ctrl (
	input wire CLK_SYS,
	input wire RSTN,
	input wire REF_TICK,
	input wire [1:0] SERIAL_MODE_SELECT,
	input wire [3:0] PIN_FUNC_SEL,
	input wire MASTER_ROLE_BIT,
	input wire CLK_POL,
	input wire CLK_PHA,
	input wire LSB_FIRST,
	input wire [3:0] CLOCK_RATE_LINEAR,
	input wire [3:0] CLOCK_RATE_EXPONENT,
	input wire TX_WR,
	input wire [7:0] TX_DATA,
	input wire RX_RD,
	output wire [7:0] RX_DATA,
	input wire DMA_TX_VALID,
	input wire [7:0] DMA_TX_DATA,
	output wire DMA_TX_READY,
	output wire DMA_RX_VALID,
	input wire DMA_RX_READY,
	output wire TX_FREE,
	output wire TX_IDLE,
	output wire RX_VALID,
	output reg RX_OVERRUN_FF,
	output wire SPI_ACTIVE,
	output reg SCLK_OUT_FF,
	output wire SCLK_OE_N,
	input wire SCLK_IN,
	output reg MOSI_OUT_FF,
	output wire MOSI_OE_N,
	input wire MISO_IN,
	output reg MISO_OUT_FF,
	output wire MISO_OE_N,
	input wire MOSI_IN,
	input wire SLAVE_SELECT_IN_N
);
	localparam [1:0] ST_IDLE = 2'h0;
	localparam [1:0] ST_SHIFT = 2'h1;
	localparam [1:0] ST_DONE = 2'h2;
	localparam [1:0] ST_LOAD = 2'h3;
	reg [1:0] state_ff;
	reg [1:0] nxt_state;
	reg [19:0] div_ff;
	reg [7:0] tx_sh_ff;
	reg [7:0] rx_sh_ff;
	reg [3:0] half_ff;
	reg sclk_in_d_ff;
	wire spi_en;
	wire pins_ok;
	wire master;
	wire [19:0] div_limit;
	wire half_tick;
	wire tx_empty;
	wire tx_full;
	wire rx_empty;
	wire rx_full;
	wire [7:0] tx_head;
	wire tx_push;
	wire [7:0] tx_wdata;
	wire tx_pop;
	reg rx_push;
	wire [7:0] rx_char;
	wire sel_ok;
	wire s_edge;
	wire shift_ev;
	wire is_sample;
	wire is_change;

	assign spi_en = (SERIAL_MODE_SELECT == `SSPI_MODE_SPI);
	assign pins_ok = spi_en && (PIN_FUNC_SEL == `SSPI_PINSEL_SPI);
	assign master = MASTER_ROLE_BIT;
	assign SPI_ACTIVE = spi_en;

	// Half period counts 24 MHz ticks: (linear+1)*2^exp. Fastest is 12 MHz.
	assign div_limit = ({16'h0000, CLOCK_RATE_LINEAR} + 20'h00001) << CLOCK_RATE_EXPONENT;
	assign half_tick = REF_TICK && (div_ff + 20'h00001 >= div_limit);
	always @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			div_ff <= 20'h00000;
		end else if (state_ff != ST_SHIFT || !master) begin
			div_ff <= 20'h00000;
		end else if (REF_TICK) begin
			div_ff <= half_tick ? 20'h00000 : div_ff + 20'h00001;
		end
	end

	// DMA takes the transmit FIFO only when software is not writing in that cycle.
	assign DMA_TX_READY = spi_en && !tx_full && !TX_WR;
	assign tx_push = spi_en && (TX_WR || DMA_TX_VALID);
	assign tx_wdata = TX_WR ? TX_DATA : DMA_TX_DATA;
	assign DMA_RX_VALID = spi_en && !rx_empty;
	assign tx_pop = (state_ff == ST_IDLE) && !tx_empty && spi_en &&
		(master || !SLAVE_SELECT_IN_N);
	assign TX_FREE = !tx_full;
	assign TX_IDLE = tx_empty && (state_ff == ST_IDLE);
	assign RX_VALID = !rx_empty;

	sspi_fifo #(.WIDTH(`SSPI_CHAR_BITS), .AW(`SSPI_FIFO_AW)) u_txf (
		.clk(CLK_SYS), .rstn(RSTN), .flush(!spi_en), .push(tx_push), .wdata(tx_wdata),
		.pop(tx_pop), .rdata_ff(tx_head), .empty(tx_empty), .full(tx_full));
	sspi_fifo #(.WIDTH(`SSPI_CHAR_BITS), .AW(`SSPI_FIFO_AW)) u_rxf (
		.clk(CLK_SYS), .rstn(RSTN), .flush(!spi_en), .push(rx_push), .wdata(rx_char),
		.pop(RX_RD || (DMA_RX_READY && spi_en)), .rdata_ff(RX_DATA), .empty(rx_empty),
		.full(rx_full));

	// Slave edges come from the external clock sampled here; 50 MHz covers 5 MHz.
	assign sel_ok = !SLAVE_SELECT_IN_N;
	// A slave edge in the load cycle is lost, so the far master must wait after selecting.
	assign s_edge = (SCLK_IN != sclk_in_d_ff);
	assign shift_ev = master ? half_tick : s_edge;
	// Odd counts are leading edges; the phase decides which edge samples.
	assign is_sample = (half_ff[0] != CLK_PHA);
	assign is_change = (half_ff[0] == CLK_PHA) && (half_ff != 4'h0);
	assign rx_char = LSB_FIRST ? {rx_sh_ff[0], rx_sh_ff[1], rx_sh_ff[2], rx_sh_ff[3],
		rx_sh_ff[4], rx_sh_ff[5], rx_sh_ff[6], rx_sh_ff[7]} : rx_sh_ff;

	assign SCLK_OE_N = !(pins_ok && master);
	assign MOSI_OE_N = !(pins_ok && master);
	assign MISO_OE_N = !(pins_ok && !master && sel_ok);

	always @* begin
		nxt_state = state_ff;
		rx_push = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				if (tx_pop) begin
					nxt_state = ST_LOAD;
				end
			end
			ST_LOAD: begin
				nxt_state = ST_SHIFT;
			end
			ST_SHIFT: begin
				if (shift_ev && half_ff == 4'h0) begin
					nxt_state = ST_DONE;
				end
			end
			ST_DONE: begin
				rx_push = 1'b1;
				nxt_state = ST_IDLE;
			end
			default: begin
				nxt_state = ST_IDLE;
			end
		endcase
		if (!spi_en) begin
			nxt_state = ST_IDLE;
		end
	end

	// Shift engine: 16 half periods per character, sample on one, change on the other.
	always @(posedge CLK_SYS or negedge RSTN) begin
		if (!RSTN) begin
			state_ff <= ST_IDLE;
			half_ff <= 4'h0;
			tx_sh_ff <= 8'h00;
			rx_sh_ff <= 8'h00;
			sclk_in_d_ff <= 1'b0;
			SCLK_OUT_FF <= 1'b0;
			MOSI_OUT_FF <= 1'b0;
			MISO_OUT_FF <= 1'b0;
			RX_OVERRUN_FF <= 1'b0;
		end else begin
			state_ff <= nxt_state;
			sclk_in_d_ff <= SCLK_IN;
			if (state_ff == ST_IDLE) begin
				SCLK_OUT_FF <= CLK_POL;
			end
			if (state_ff == ST_LOAD) begin
				half_ff <= 4'hF;
				if (CLK_PHA) begin
					tx_sh_ff <= tx_head;
				end else begin
					// Phase zero must show the first bit before the first edge.
					tx_sh_ff <= LSB_FIRST ? {1'b0, tx_head[7:1]} : {tx_head[6:0], 1'b0};
					MOSI_OUT_FF <= LSB_FIRST ? tx_head[0] : tx_head[7];
					MISO_OUT_FF <= LSB_FIRST ? tx_head[0] : tx_head[7];
				end
			end else if (state_ff == ST_SHIFT && shift_ev) begin
				if (master) begin
					SCLK_OUT_FF <= !SCLK_OUT_FF;
				end
				if (is_sample) begin
					rx_sh_ff <= {rx_sh_ff[6:0], master ? MISO_IN : MOSI_IN};
				end
				if (is_change) begin
					MOSI_OUT_FF <= LSB_FIRST ? tx_sh_ff[0] : tx_sh_ff[7];
					MISO_OUT_FF <= LSB_FIRST ? tx_sh_ff[0] : tx_sh_ff[7];
					tx_sh_ff <= LSB_FIRST ? {1'b0, tx_sh_ff[7:1]} : {tx_sh_ff[6:0], 1'b0};
				end
				if (half_ff != 4'h0) begin
					half_ff <= half_ff - 4'h1;
				end
			end
			if (rx_push && rx_full) begin
				RX_OVERRUN_FF <= 1'b1;
			end else if (RX_RD) begin
				RX_OVERRUN_FF <= 1'b0;
			end
		end
	end
endmodule

// File: design/sspi_fifo.v
// Small character FIFO with registered read data.
// Assumes one clock; push ignored when full, pop ignored when empty.
`timescale 1ns/1ns
`include "sspi_defines.vh"
module sspi_fifo #(
	parameter WIDTH = 8,
	parameter AW = 2
) (
	input wire clk,
	input wire rstn,
	input wire flush,
	input wire push,
	input wire [WIDTH-1:0] wdata,
	input wire pop,
	output reg [WIDTH-1:0] rdata_ff,
	output wire empty,
	output wire full
);
	localparam [AW:0] DEPTH = {1'b1, {AW{1'b0}}};
	reg [WIDTH-1:0] mem [0:(1<<AW)-1];
	reg [AW-1:0] wp_ff;
	reg [AW-1:0] rp_ff;
	reg [AW:0] cnt_ff;
	wire do_push;
	wire do_pop;
	assign empty = (cnt_ff == {(AW+1){1'b0}});
	assign full = (cnt_ff == DEPTH);
	assign do_push = push && !full;
	assign do_pop = pop && !empty;
	always @(posedge clk) begin
		if (do_push) begin
			mem[wp_ff] <= wdata;
		end
	end
	always @(posedge clk or negedge rstn) begin
		if (!rstn) begin
			wp_ff <= {AW{1'b0}};
			rp_ff <= {AW{1'b0}};
			cnt_ff <= {(AW+1){1'b0}};
			rdata_ff <= {WIDTH{1'b0}};
		end else if (flush) begin
			wp_ff <= {AW{1'b0}};
			rp_ff <= {AW{1'b0}};
			cnt_ff <= {(AW+1){1'b0}};
		end else begin
			if (do_push) begin
				wp_ff <= wp_ff + 1'b1;
			end
			if (do_pop) begin
				rdata_ff <= mem[rp_ff];
				rp_ff <= rp_ff + 1'b1;
			end
			if (do_push && !do_pop) begin
				cnt_ff <= cnt_ff + 1'b1;
			end else if (do_pop && !do_push) begin
				cnt_ff <= cnt_ff - 1'b1;
			end
		end
	end
endmodule
